// ---- rtl/clock_gen_i2c_control_port.v ----
// Serial control port and output gating of the clock generator
//
// What this block does
// - Top bit clear means block, count follows
// - Block steps registers upward, MSB first
// - Byte mode touches only the indexed register
// - Strap sampled once at first release
// - Strap low 1101001, strap high 1101010
// - Block write acks address, command, count, data
// - Block read sends count, then data bytes
// - Byte write acks address, command, data
// - Byte read returns one byte, then nack
// - Byte 0 gates outputs 7 to 0
// - Byte 1 gates 11 to 8, reserved zero
// - Byte 1 low bits show latched spread
// - Byte 2 bit 7 picks spread source
// - Soft spread field, same code, resets 01
// - Byte 2 bit 3 enables reference output
// - Keep-alive keeps reference during power down
// - Registers default at power up
// - Power down stops differential outputs and port
// - Output runs on pin low and bit high
// - Disabled output stops cleanly, held low
`timescale 1ns/10ps
`include "clkgen_port_defs.vh"

module clock_gen_i2c_control_port #(
  parameter PCIE_CLOCK_OUT_OUTPUTS = 12,
  parameter [7:0] REF_HALF = `REF_HALF_CYCLES
) (
  input wire MCLK,
  input wire ARST_N,
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  input wire POWER_DOWN_N,
  input wire TARGET_ADDRESS_STRAP,
  input wire [1:0] SPREAD_PIN,
  input wire [PCIE_CLOCK_OUT_OUTPUTS-1:0] OUTPUT_GATE_PIN_N,
  output reg [PCIE_CLOCK_OUT_OUTPUTS-1:0] PCIE_CLOCK_OUT,
  output reg REF_CLOCK_OUT,
  output reg [1:0] SPREAD_SETTING
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RECV = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_SEND = 3'h3;
  localparam [2:0] ST_MACK = 3'h4;
  localparam [2:0] ST_MNEXT = 3'h5;

  localparam [1:0] ROLE_ADDR = 2'h0;
  localparam [1:0] ROLE_CMD = 2'h1;
  localparam [1:0] ROLE_COUNT = 2'h2;
  localparam [1:0] ROLE_DATA = 2'h3;

  // ==========================================================
  // Input synchronisers
  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg [1:0] pd_sync;
  reg [1:0] strap_sync;
  reg [3:0] spread_sync;
  reg [PCIE_CLOCK_OUT_OUTPUTS-1:0] gate_meta;
  reg [PCIE_CLOCK_OUT_OUTPUTS-1:0] gate_pin_n;
  reg pd_prev;

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      pd_sync <= 2'h0;
      strap_sync <= 2'h0;
      spread_sync <= 4'h0;
      gate_meta <= {PCIE_CLOCK_OUT_OUTPUTS{1'b0}};
      gate_pin_n <= {PCIE_CLOCK_OUT_OUTPUTS{1'b0}};
      pd_prev <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[1:0], SCL_IN};
      sda_sync <= {sda_sync[1:0], SDA_IN};
      pd_sync <= {pd_sync[0], POWER_DOWN_N};
      strap_sync <= {strap_sync[0], TARGET_ADDRESS_STRAP};
      spread_sync <= {spread_sync[1:0], SPREAD_PIN};
      gate_meta <= OUTPUT_GATE_PIN_N;
      gate_pin_n <= gate_meta;
      pd_prev <= pd_sync[1];
    end
  end

  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire scl_rise = scl & ~scl_sync[2];
  wire scl_fall = ~scl & scl_sync[2];
  wire bus_start = scl & scl_sync[2] & ~sda & sda_sync[2];
  wire bus_stop = scl & scl_sync[2] & sda & ~sda_sync[2];
  wire powered = pd_sync[1];

  // ==========================================================
  // Power-up latches
  // Caught only once; a later power-down cycle keeps the address
  reg latched;
  reg strap_value;
  reg [1:0] spread_latched;

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      latched <= 1'b0;
      strap_value <= 1'b0;
      spread_latched <= `RST_SPREAD_LATCH;
    end else if (!latched && powered && !pd_prev) begin
      latched <= 1'b1;
      strap_value <= strap_sync[1];
      spread_latched <= spread_sync[3:2];
    end
  end

  wire [6:0] own_addr = strap_value ?
    `ADDR_STRAP_HIGH : `ADDR_STRAP_LOW;

  // ==========================================================
  // Control registers
  reg [7:0] pcie_clock_out_output_enable_low;
  reg [3:0] pcie_clock_out_enable_high;
  reg spread_source_select;
  reg [1:0] spread_soft_code;
  reg ref_enable;
  reg lvcmos_keep_alive;

  // ==========================================================
  // Serial engine
  reg [2:0] state;
  reg [1:0] role;
  reg [3:0] bitcnt;
  reg [7:0] shift;
  reg [7:0] tx;
  reg [6:0] index;
  reg byte_mode;
  reg reading;
  reg count_sent;
  reg [7:0] rd_byte;
  reg [7:0] next_tx;
  reg [6:0] next_index;

  always @* begin
    case (index)
      `IDX_PCIE_CLOCK_OUT_EN_LOW: rd_byte = pcie_clock_out_output_enable_low;
      `IDX_PCIE_CLOCK_OUT_EN_HIGH: rd_byte = {pcie_clock_out_enable_high, 2'h0,
        spread_latched};
      `IDX_SPREAD_REF: rd_byte = {spread_source_select,
        spread_soft_code, 1'b0, ref_enable, lvcmos_keep_alive,
        2'h0};
      default: rd_byte = 8'h00;
    endcase
  end

  // Next byte to send: block reads open with the count
  always @* begin
    next_tx = rd_byte;
    next_index = index;
    if (!byte_mode && !count_sent) begin
      next_tx = `BLOCK_READ_COUNT;
    end else if (!byte_mode) begin
      next_index = index + 7'h01;
    end
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
      role <= ROLE_ADDR;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      index <= 7'h00;
      byte_mode <= 1'b0;
      reading <= 1'b0;
      count_sent <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      pcie_clock_out_output_enable_low <= `RST_PCIE_CLOCK_OUT_EN_LOW;
      pcie_clock_out_enable_high <= `RST_PCIE_CLOCK_OUT_EN_HIGH;
      spread_source_select <= `RST_SPREAD_SRC;
      spread_soft_code <= `RST_SPREAD_SOFT;
      ref_enable <= `RST_REF_EN;
      lvcmos_keep_alive <= `RST_KEEP_ALIVE;
    end else if (!powered) begin
      state <= ST_IDLE;
      SDA_OE <= 1'b0;
    end else if (bus_start) begin
      state <= ST_RECV;
      role <= ROLE_ADDR;
      bitcnt <= 4'h0;
      SDA_OE <= 1'b0;
    end else if (bus_stop) begin
      state <= ST_IDLE;
      SDA_OE <= 1'b0;
    end else begin
      case (state)
        ST_RECV: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == `BITS_PER_BYTE) begin
            bitcnt <= 4'h0;
            SDA_OE <= 1'b1;
            state <= ST_ACK;
            case (role)
              ROLE_ADDR: begin
                if (shift[7:1] != own_addr) begin
                  SDA_OE <= 1'b0;
                  state <= ST_IDLE;
                end else begin
                  reading <= shift[0];
                  count_sent <= 1'b0;
                  role <= ROLE_CMD;
                end
              end
              ROLE_CMD: begin
                byte_mode <= shift[`CMD_BYTE_MODE_BIT];
                index <= shift[6:0];
                role <= shift[`CMD_BYTE_MODE_BIT] ?
                  ROLE_DATA : ROLE_COUNT;
              end
              ROLE_COUNT: begin
                role <= ROLE_DATA;
              end
              default: begin
                case (index)
                  `IDX_PCIE_CLOCK_OUT_EN_LOW:
                    pcie_clock_out_output_enable_low <= shift;
                  `IDX_PCIE_CLOCK_OUT_EN_HIGH:
                    pcie_clock_out_enable_high <=
                      shift[`B1_EN_MSB:`B1_EN_LSB];
                  `IDX_SPREAD_REF: begin
                    spread_source_select <=
                      shift[`B2_SRC_BIT];
                    spread_soft_code <=
                      shift[`B2_SOFT_MSB:`B2_SOFT_LSB];
                    ref_enable <= shift[`B2_REF_EN_BIT];
                    lvcmos_keep_alive <= shift[`B2_KEEP_BIT];
                  end
                  default: index <= index;
                endcase
                if (!byte_mode) begin
                  index <= index + 7'h01;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (reading) begin
              tx <= next_tx;
              index <= next_index;
              count_sent <= 1'b1;
              SDA_OE <= ~next_tx[7];
              state <= ST_SEND;
            end else begin
              SDA_OE <= 1'b0;
              state <= ST_RECV;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bitcnt == `BITS_PER_BYTE - 4'h1) begin
              bitcnt <= 4'h0;
              SDA_OE <= 1'b0;
              state <= ST_MACK;
            end else begin
              bitcnt <= bitcnt + 4'h1;
              tx <= {tx[6:0], 1'b0};
              SDA_OE <= ~tx[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            // A nack ends the read; the port goes idle until the next start
            state <= sda ? ST_IDLE : ST_MNEXT;
          end
        end
        ST_MNEXT: begin
          if (scl_fall) begin
            tx <= next_tx;
            index <= next_index;
            count_sent <= 1'b1;
            SDA_OE <= ~next_tx[7];
            state <= ST_SEND;
          end
        end
        default: begin
          SDA_OE <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Differential output gating
  // Enable is taken only at the start of a high phase, so a
  // change never cuts a pulse short
  reg pcie_clock_out_phase;
  wire [PCIE_CLOCK_OUT_OUTPUTS-1:0] reg_enables;
  assign reg_enables = {pcie_clock_out_enable_high,
    pcie_clock_out_output_enable_low};
  wire [PCIE_CLOCK_OUT_OUTPUTS-1:0] pcie_clock_out_run = reg_enables & ~gate_pin_n &
    {PCIE_CLOCK_OUT_OUTPUTS{powered}};

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pcie_clock_out_phase <= 1'b0;
      PCIE_CLOCK_OUT <= {PCIE_CLOCK_OUT_OUTPUTS{1'b0}};
    end else begin
      pcie_clock_out_phase <= ~pcie_clock_out_phase;
      PCIE_CLOCK_OUT <= pcie_clock_out_phase ?
        {PCIE_CLOCK_OUT_OUTPUTS{1'b0}} : pcie_clock_out_run;
    end
  end

  // ==========================================================
  // Reference output gating
  reg [7:0] ref_count;
  reg ref_phase;
  reg ref_run;
  wire ref_allowed = ref_enable &
    (powered | lvcmos_keep_alive);

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ref_count <= 8'h00;
      ref_phase <= 1'b0;
      ref_run <= 1'b0;
      REF_CLOCK_OUT <= 1'b0;
    end else begin
      if (ref_count == REF_HALF - 8'h01) begin
        ref_count <= 8'h00;
        ref_phase <= ~ref_phase;
        if (!ref_phase) begin
          ref_run <= ref_allowed;
          REF_CLOCK_OUT <= ref_allowed;
        end else begin
          REF_CLOCK_OUT <= 1'b0;
        end
      end else begin
        ref_count <= ref_count + 8'h01;
        REF_CLOCK_OUT <= ref_phase & ref_run;
      end
    end
  end

  // ==========================================================
  // Effective spread setting
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SPREAD_SETTING <= `RST_SPREAD_LATCH;
    end else begin
      SPREAD_SETTING <= spread_source_select ?
        spread_soft_code : spread_latched;
    end
  end

endmodule

// ---- rtl/clkgen_port_defs.vh ----
// Constants for the clock generator serial control port
`ifndef CLKGEN_PORT_DEFS_VH
`define CLKGEN_PORT_DEFS_VH

// ==========================================================
// Target addresses selected by the strap
`define ADDR_STRAP_LOW 7'h69
`define ADDR_STRAP_HIGH 7'h6a

// ==========================================================
// Register indices
`define IDX_PCIE_CLOCK_OUT_EN_LOW 7'h00
`define IDX_PCIE_CLOCK_OUT_EN_HIGH 7'h01
`define IDX_SPREAD_REF 7'h02

// ==========================================================
// Reset values
`define RST_PCIE_CLOCK_OUT_EN_LOW 8'hff
`define RST_PCIE_CLOCK_OUT_EN_HIGH 4'hf
`define RST_SPREAD_LATCH 2'h0
`define RST_SPREAD_SRC 1'h0
`define RST_SPREAD_SOFT 2'h1
`define RST_REF_EN 1'h1
`define RST_KEEP_ALIVE 1'h0

// ==========================================================
// Field positions
`define CMD_BYTE_MODE_BIT 7
`define B1_EN_MSB 7
`define B1_EN_LSB 4
`define B2_SRC_BIT 7
`define B2_SOFT_MSB 6
`define B2_SOFT_LSB 5
`define B2_REF_EN_BIT 3
`define B2_KEEP_BIT 2

// ==========================================================
// Block read count and timing
`define BLOCK_READ_COUNT 8'h03
`define BITS_PER_BYTE 4'h8
`define REF_HALF_CYCLES 8'h03

`endif

// ---- testbench/clkgen_port_asserts.sv ----
// Pin-level checks for the clock generator control port
`timescale 1ns/10ps
module clkgen_port_asserts #(
  parameter int PCIE_CLOCK_OUT_OUTPUTS = 12,
  parameter int REF_HALF = 3
) (
  input wire MCLK,
  input wire ARST_N,
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire POWER_DOWN_N,
  input wire TARGET_ADDRESS_STRAP,
  input wire [1:0] SPREAD_PIN,
  input wire [PCIE_CLOCK_OUT_OUTPUTS-1:0] OUTPUT_GATE_PIN_N,
  input wire [PCIE_CLOCK_OUT_OUTPUTS-1:0] PCIE_CLOCK_OUT,
  input wire REF_CLOCK_OUT,
  input wire [1:0] SPREAD_SETTING
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // ==========================================
  // Serial port
  chk_open_drain: assert property (!SDA_OUT)
    else $error("SDA driven high");
  chk_ack_in_low: assert property ($rose(SDA_OE) |-> !SCL_IN)
    else $error("SDA taken while SCL high");
  chk_oe_hold_high: assert property (
    SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE))
    else $error("SDA moved while SCL high");
  chk_pd_released: assert property (
    !POWER_DOWN_N [*6] |-> !SDA_OE)
    else $error("SDA held in power down");
  // ==========================================
  // Output clocks
  chk_pd_quiet: assert property (
    !POWER_DOWN_N [*6] |-> PCIE_CLOCK_OUT == '0)
    else $error("output running in power down");
  chk_gate_pin: assert property ($stable(OUTPUT_GATE_PIN_N) [*6]
    |-> (PCIE_CLOCK_OUT & OUTPUT_GATE_PIN_N) == '0)
    else $error("output runs with gate pin high");
  chk_pulse_whole: assert property (
    |PCIE_CLOCK_OUT |=> PCIE_CLOCK_OUT == '0)
    else $error("output pulse stretched");
  chk_ref_half: assert property (
    $rose(REF_CLOCK_OUT) |-> ##REF_HALF $fell(REF_CLOCK_OUT))
    else $error("reference pulse cut or stretched");
  cov_ack: cover property ($rose(SDA_OE));
  cov_keep_alive: cover property (!POWER_DOWN_N [*8] ##1 REF_CLOCK_OUT);
  cov_spread: cover property ($changed(SPREAD_SETTING));
endmodule

bind clock_gen_i2c_control_port clkgen_port_asserts #(
  .PCIE_CLOCK_OUT_OUTPUTS(PCIE_CLOCK_OUT_OUTPUTS),
  .REF_HALF(REF_HALF)
) chk (
  .MCLK(MCLK), .ARST_N(ARST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .POWER_DOWN_N(POWER_DOWN_N),
  .TARGET_ADDRESS_STRAP(TARGET_ADDRESS_STRAP), .SPREAD_PIN(SPREAD_PIN),
  .OUTPUT_GATE_PIN_N(OUTPUT_GATE_PIN_N), .PCIE_CLOCK_OUT(PCIE_CLOCK_OUT),
  .REF_CLOCK_OUT(REF_CLOCK_OUT), .SPREAD_SETTING(SPREAD_SETTING)
);

// ---- testbench/i2c_ctl_model.sv ----
// Behavioural serial bus controller for the control port
`timescale 1ns/10ps
module i2c_ctl_model (
  output logic scl,
  output logic sda,
  input wire logic line
);
  // ==========================================
  // 125 ns bits; slow stretches the low phase
  localparam realtime Q = 31.25;
  int slow = 0;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    #Q sda = b;
    #(Q * (slow + 1)) scl = 1'b1;
    #Q r = line;
    #Q scl = 1'b0;
  endtask
  task automatic start;
    #Q sda = 1'b1;
    #Q scl = 1'b1;
    #Q sda = 1'b0;
    #Q scl = 1'b0;
  endtask
  task automatic stop;
    #Q sda = 1'b0;
    #Q scl = 1'b1;
    #Q sda = 1'b1;
  endtask
  // High last bit frees SDA for the ack, or nacks a read
  task automatic xfer(input logic [7:0] d, input logic last,
    output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, a);
    ack = ~a;
  endtask
endmodule

// ---- testbench/tb_clock_gen_i2c_control_port.sv ----
// Self-checking bench for the clock generator control port
`timescale 1ns/10ps
module tb_clock_gen_i2c_control_port;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic pd_n = 1'b0;
  logic strap = 1'b0;
  logic [1:0] sp = 2'h0;
  logic [1:0] sl = 2'h0;
  logic [11:0] pins = 12'h000;
  logic [7:0] m [0:2];
  logic [6:0] addr = 7'h00;
  int n_errors = 0;
  int num_checks = 0;
  wire scl, sda_m, sda_out, sda_oe, ref_out;
  wire [11:0] pcie;
  wire [1:0] spread;
  // Pull-up: high unless a party pulls low
  wire sda = sda_m & ~(sda_oe & ~sda_out);

  i2c_ctl_model ctl (.scl(scl), .sda(sda_m), .line(sda));
  clock_gen_i2c_control_port dut (
    .MCLK(mclk), .ARST_N(arst_n), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .POWER_DOWN_N(pd_n),
    .TARGET_ADDRESS_STRAP(strap), .SPREAD_PIN(sp),
    .OUTPUT_GATE_PIN_N(pins), .PCIE_CLOCK_OUT(pcie),
    .REF_CLOCK_OUT(ref_out), .SPREAD_SETTING(spread)
  );
  initial begin
    forever #4 mclk = ~mclk;
  end
  // ==========================================
  // Checking and model
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] ex(input logic [6:0] i);
    return i > 2 ? 8'h00 : i == 1 ? {m[1][7:4], 2'b00, sl} : m[i];
  endfunction
  task automatic upd(input logic [6:0] i, input logic [7:0] d);
    logic [7:0] k;
    k = i == 0 ? 8'hff : i == 1 ? 8'hf0 : 8'hec;
    if (i < 3) m[i] = (m[i] & ~k) | (d & k);
  endtask
  // ==========================================
  // Bus transactions
  task automatic hdr(input logic [7:0] c, output logic ok);
    logic [7:0] q;
    logic a, b;
    ctl.start();
    ctl.xfer({addr, 1'b0}, 1'b1, q, a);
    ctl.xfer(c, 1'b1, q, b);
    ok = a & b;
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic ok, a;
    hdr({1'b1, i}, ok);
    ctl.xfer(d, 1'b1, q, a);
    ctl.stop();
    check({ok, a}, 2'b11);
    upd(i, d);
  endtask
  task automatic rd(input logic [6:0] i, input logic blk);
    logic [7:0] q;
    logic ok, a;
    hdr({~blk, i}, ok);
    ctl.start();
    ctl.xfer({addr, 1'b1}, 1'b1, q, a);
    check({ok, a}, 2'b11);
    ctl.xfer(8'hff, blk ? 1'b0 : 1'b1, q, a);
    check(q, blk ? 8'h03 : ex(i));
    for (int k = 0; blk && k < 3; k++) begin
      ctl.xfer(8'hff, k == 2, q, a);
      check(q, ex(i + 7'(k)));
    end
    ctl.stop();
  endtask
  task automatic blk_wr(input logic [6:0] i, input logic [7:0] n);
    logic [7:0] q, d;
    logic ok, a;
    hdr({1'b0, i}, ok);
    ctl.xfer(n, 1'b1, q, a);
    ok &= a;
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      ctl.xfer(d, 1'b1, q, a);
      ok &= a;
      upd(i + 7'(k), d);
    end
    ctl.stop();
    check(ok, 1'b1);
  endtask
  task automatic chk_out;
    logic [11:0] seen;
    logic r;
    repeat (16) @(negedge mclk);
    seen = '0;
    r = 1'b0;
    repeat (8) begin
      @(negedge mclk);
      seen |= pcie;
      r |= ref_out;
    end
    check(seen, pd_n ? {m[1][7:4], m[0]} & ~pins : 12'h0);
    check(r, m[2][3] & (pd_n | m[2][2]));
    check(spread, m[2][7] ? m[2][6:5] : sl);
  endtask
  task automatic pwr_up;
    @(posedge mclk);
    arst_n <= 1'b0;
    pd_n <= 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    pd_n <= 1'b1;
    sl = sp;
    repeat (10) @(posedge mclk);
    m = '{8'hff, 8'hf0, 8'h28};
    addr = strap ? 7'h6a : 7'h69;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // ==========================================
  // Scenarios
  initial begin
    logic [7:0] d;
    logic ok;
    void'($urandom(27));
    @(posedge mclk);
    strap <= 1'($urandom);
    sp <= 2'($urandom);
    pwr_up();
    for (int j = 0; j < 3; j++) rd(7'(j), 1'b0);
    chk_out();
    done("defaults");
    for (int t = 0; t < 8; t++) begin
      @(posedge mclk);
      pins <= 12'($urandom);
      sp <= 2'($urandom);
      wr(7'($urandom_range(3)), 8'($urandom));
      for (int j = 0; j < 4; j++) rd(7'(j), 1'b0);
      chk_out();
    end
    done("byte random");
    ctl.slow = 3;
    blk_wr(7'h00, 8'h03);
    rd(7'h00, 1'b1);
    blk_wr(7'h01, 8'h01);
    blk_wr(7'h02, 8'h20);
    rd(7'h00, 1'b1);
    ctl.slow = 0;
    done("block");
    wr(7'h02, 8'he8);
    chk_out();
    done("soft spread");
    ctl.start();
    ctl.xfer({addr ^ 7'h03, 1'b0}, 1'b1, d, ok);
    check(ok, 1'b0);
    ctl.xfer({addr, 1'b0}, 1'b1, d, ok);
    check(ok, 1'b0);
    ctl.stop();
    rd(7'h00, 1'b0);
    done("foreign address");
    wr(7'h02, 8'h0c);
    @(posedge mclk);
    pd_n <= 1'b0;
    strap <= ~strap;
    chk_out();
    hdr(8'h80, ok);
    ctl.stop();
    check(ok, 1'b0);
    @(posedge mclk);
    pd_n <= 1'b1;
    wr(7'h02, 8'h08);
    @(posedge mclk);
    pd_n <= 1'b0;
    chk_out();
    @(posedge mclk);
    pd_n <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(7'h02, 1'b0);
    done("power down");
    pwr_up();
    for (int j = 0; j < 3; j++) rd(7'(j), 1'b0);
    chk_out();
    done("second power-up");
    print_verdict();
  end
  initial begin
    repeat (95000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end
endmodule
